// File: src/fpsc_consts.svh
/*
 * Constants of the floating-point state block: register file size,
 * control register field positions, reset values and codes.
 * Assumes inclusion by bare name from the block's design files.
 */
// Overview of operation
// [RULE1] 32 floating-point registers of 32 bits, apart from integer ones.
// [RULE2] One 32-bit control register holding round mode and accrued flags.
// [RULE3] Full read returns the whole control register value.
// [RULE4] Full swap returns old value, then loads source value.
// [RULE5] Round field is bits 7..5; its read zero-extends into low bits.
// [RULE6] Round swap returns old field, loads source bits 2..0.
// [RULE7] Flag field is bits 4..0, with read and swap like round field.
// [RULE8] Bits 31..8 ignore writes and read as zero.
// [RULE9] Software should preserve reserved upper bits when writing.
// [RULE10] Instruction round code used; code 111 selects the dynamic field.
// [RULE11] Codes 000 to 100 decode to the five rounding directions.
// [RULE12] Reserved codes flagged illegal: static 101-110, dynamic 101-111.
// [RULE13] Rounding field always decoded, even where result does not depend.
// [RULE14] Five accrued flags are sticky until software clears them.
// [RULE15] Setting a flag never traps; software reads flags explicitly.
// [RULE16] Flags: 4 invalid, 3 div zero, 2 overflow, 1 underflow, 0 inexact.
`ifndef FPSC_CONSTS_SVH
`define FPSC_CONSTS_SVH

// ------------------------------------------------------------
// Register file
// ------------------------------------------------------------
`define FPSC_NREGS 32
`define FPSC_REG_W 32
`define FPSC_ADDR_W 5
`define FPSC_REG_RESET 32'h0000_0000

// ------------------------------------------------------------
// Control register layout
// ------------------------------------------------------------
`define FPSC_CSR_W 32
`define FPSC_LIVE_W 8
`define FPSC_ROUND_HI 7
`define FPSC_ROUND_LO 5
`define FPSC_FLAG_HI 4
`define FPSC_FLAG_LO 0
`define FPSC_ROUND_W 3
`define FPSC_FLAG_W 5
`define FPSC_LIVE_RESET 8'h00
`define FPSC_UPPER_ZERO 24'h00_0000

// ------------------------------------------------------------
// Rounding codes
// ------------------------------------------------------------
`define FPSC_RC_LAST_LEGAL 3'h4
`define FPSC_RC_USE_DYNAMIC 3'h7

`endif

// File: src/fpsc_pkg.sv
/*
 * Types of the floating-point state block.
 * Assumes fpsc_consts.svh is reachable on the include path.
 */
`default_nettype none
`include "fpsc_consts.svh"
package fpsc_pkg;
	// ------------------------------------------------------------
	// Control register access kinds
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		read_full_fp_control = 3'h0,
		swap_full_fp_control = 3'h1,
		read_round_field = 3'h2,
		swap_round_field = 3'h3,
		read_flag_field = 3'h4,
		swap_flag_field = 3'h5
	} fpsc_csr_op_e;

	// ------------------------------------------------------------
	// Rounding modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		nearest_even = 3'h0,
		toward_zero = 3'h1,
		toward_neg_inf = 3'h2,
		toward_pos_inf = 3'h3,
		nearest_max_magnitude = 3'h4,
		round_rsv5 = 3'h5,
		round_rsv6 = 3'h6,
		use_dynamic_round = 3'h7
	} fpsc_round_e;

	typedef logic [`FPSC_REG_W-1:0] fpsc_word_t;
	typedef logic [`FPSC_ADDR_W-1:0] fpsc_addr_t;
endpackage : fpsc_pkg
`default_nettype wire

// File: src/fpsc_rf_if.sv
/*
 * Carrier between the control logic and the register array.
 * Assumes one write port and three registered read ports.
 */
`default_nettype none
`include "fpsc_consts.svh"
interface fpsc_rf_if;
	logic wr_en;
	fpsc_pkg::fpsc_addr_t wr_addr;
	fpsc_pkg::fpsc_word_t wr_data;
	fpsc_pkg::fpsc_addr_t rd_addr_a;
	fpsc_pkg::fpsc_addr_t rd_addr_b;
	fpsc_pkg::fpsc_addr_t rd_addr_c;
	fpsc_pkg::fpsc_word_t rd_data_a;
	fpsc_pkg::fpsc_word_t rd_data_b;
	fpsc_pkg::fpsc_word_t rd_data_c;

	modport regs (
		input wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b, rd_addr_c,
		output rd_data_a, rd_data_b, rd_data_c
	);
	modport core (
		output wr_en, wr_addr, wr_data, rd_addr_a, rd_addr_b, rd_addr_c,
		input rd_data_a, rd_data_b, rd_data_c
	);
endinterface : fpsc_rf_if
`default_nettype wire

// File: src/fpsc_regfile.sv
/*
 * Thirty-two word floating-point register array with registered reads.
 * Assumes synchronous active-high reset and a clock enable from the top.
 */
`default_nettype none
`include "fpsc_consts.svh"
module fpsc_regfile (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Array ports
	fpsc_rf_if.regs rf
);
	fpsc_pkg::fpsc_word_t mem [`FPSC_NREGS];
	fpsc_pkg::fpsc_word_t next_mem [`FPSC_NREGS];
	fpsc_pkg::fpsc_word_t rda;
	fpsc_pkg::fpsc_word_t rdb;
	fpsc_pkg::fpsc_word_t rdc;
	fpsc_pkg::fpsc_word_t next_rda;
	fpsc_pkg::fpsc_word_t next_rdb;
	fpsc_pkg::fpsc_word_t next_rdc;

	// ------------------------------------------------------------
	// Next state: write port and read ports, old value on collision
	// ------------------------------------------------------------
	always_comb begin
		for (int i = 0; i < `FPSC_NREGS; i++) begin
			next_mem[i] = mem[i];
		end
		if (rf.wr_en) begin
			next_mem[rf.wr_addr] = rf.wr_data; // [RULE1]
		end
		next_rda = mem[rf.rd_addr_a];
		next_rdb = mem[rf.rd_addr_b];
		next_rdc = mem[rf.rd_addr_c];
	end

	// Registers, frozen while the enable is low
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			for (int i = 0; i < `FPSC_NREGS; i++) begin
				mem[i] <= `FPSC_REG_RESET;
			end
			rda <= `FPSC_REG_RESET;
			rdb <= `FPSC_REG_RESET;
			rdc <= `FPSC_REG_RESET;
		end else if (clk_en) begin
			mem <= next_mem;
			rda <= next_rda;
			rdb <= next_rdb;
			rdc <= next_rdc;
		end
	end

	assign rf.rd_data_a = rda;
	assign rf.rd_data_b = rdb;
	assign rf.rd_data_c = rdc;
endmodule : fpsc_regfile
`default_nettype wire

// File: src/fpsc_top.sv
/*
 * Floating-point architectural state: register array, control and
 * status register with whole and field accesses, rounding-mode
 * resolution and sticky exception flag accrual.
 * Assumes the execution pipeline drives all requests synchronously to
 * clk, holds clk_en low to stall, and keeps at most one control access
 * per cycle.
 */
`default_nettype none
`include "fpsc_consts.svh"
module fpsc_top (
	// Clock, reset, enable
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Register array write port
	input wire logic fp_wr_en,
	input wire logic [`FPSC_ADDR_W-1:0] fp_wr_addr,
	input wire logic [`FPSC_REG_W-1:0] fp_wr_data,
	// Register array read ports, data one cycle after address
	input wire logic [`FPSC_ADDR_W-1:0] fp_rd_addr_a,
	input wire logic [`FPSC_ADDR_W-1:0] fp_rd_addr_b,
	input wire logic [`FPSC_ADDR_W-1:0] fp_rd_addr_c,
	output logic [`FPSC_REG_W-1:0] fp_rd_data_a,
	output logic [`FPSC_REG_W-1:0] fp_rd_data_b,
	output logic [`FPSC_REG_W-1:0] fp_rd_data_c,
	// Control register access
	input wire logic csr_req,
	input wire logic [2:0] csr_op,
	input wire logic [`FPSC_CSR_W-1:0] src_int_reg,
	output logic csr_done,
	output logic [`FPSC_CSR_W-1:0] csr_rdata,
	// Rounding resolution
	input wire logic round_req,
	input wire logic [`FPSC_ROUND_W-1:0] instr_round_field,
	output logic round_done,
	output logic [`FPSC_ROUND_W-1:0] round_mode,
	output logic round_illegal,
	// Exception flags raised by arithmetic
	input wire logic flag_valid,
	input wire logic [`FPSC_FLAG_W-1:0] flag_bits,
	// Live view of the control register fields
	output logic [`FPSC_ROUND_W-1:0] dynamic_round,
	output logic [`FPSC_FLAG_W-1:0] accrued_flags
);
	// ------------------------------------------------------------
	// Helper functions
	// ------------------------------------------------------------

	// True when a rounding code names no legal direction
	function automatic logic round_reserved(
		input logic [`FPSC_ROUND_W-1:0] code
	);
		round_reserved = (code > `FPSC_RC_LAST_LEGAL); // [RULE12]
	endfunction : round_reserved

	// Whole register view: upper bits always zero
	function automatic logic [`FPSC_CSR_W-1:0] csr_view(
		input logic [`FPSC_ROUND_W-1:0] rnd,
		input logic [`FPSC_FLAG_W-1:0] flg
	);
		csr_view = {`FPSC_UPPER_ZERO, rnd, flg}; // [RULE8]
	endfunction : csr_view

	// Round field of a word laid out as the whole register
	function automatic logic [`FPSC_ROUND_W-1:0] round_of(
		input logic [`FPSC_CSR_W-1:0] word
	);
		round_of = word[`FPSC_ROUND_HI:`FPSC_ROUND_LO]; // [RULE5]
	endfunction : round_of

	// Flag field of a word laid out as the whole register
	function automatic logic [`FPSC_FLAG_W-1:0] flags_of(
		input logic [`FPSC_CSR_W-1:0] word
	);
		flags_of = word[`FPSC_FLAG_HI:`FPSC_FLAG_LO]; // [RULE7]
	endfunction : flags_of

	// Round field alone, zero-extended into the low bits
	function automatic logic [`FPSC_CSR_W-1:0] round_word(
		input logic [`FPSC_ROUND_W-1:0] rnd
	);
		round_word = `FPSC_CSR_W'(rnd); // [RULE5]
	endfunction : round_word

	// Flag field alone, zero-extended into the low bits
	function automatic logic [`FPSC_CSR_W-1:0] flag_word(
		input logic [`FPSC_FLAG_W-1:0] flg
	);
		flag_word = `FPSC_CSR_W'(flg); // [RULE7]
	endfunction : flag_word

	// ------------------------------------------------------------
	// Register array
	// ------------------------------------------------------------
	fpsc_rf_if rf_bus ();

	// Array ports forwarded to the carrier
	assign rf_bus.wr_en = fp_wr_en;
	assign rf_bus.wr_addr = fp_wr_addr;
	assign rf_bus.wr_data = fp_wr_data;
	assign rf_bus.rd_addr_a = fp_rd_addr_a;
	assign rf_bus.rd_addr_b = fp_rd_addr_b;
	assign rf_bus.rd_addr_c = fp_rd_addr_c;

	fpsc_regfile u_regs (
		.clk(clk),
		.sys_rst(sys_rst),
		.clk_en(clk_en),
		.rf(rf_bus.regs)
	);

	// Read data comes from the array's own output flops
	assign fp_rd_data_a = rf_bus.rd_data_a; // [RULE1]
	assign fp_rd_data_b = rf_bus.rd_data_b;
	assign fp_rd_data_c = rf_bus.rd_data_c;

	// ------------------------------------------------------------
	// Control register state
	// ------------------------------------------------------------
	// Only the eight live bits are stored; the rest is constant zero.
	logic [`FPSC_LIVE_W-1:0] live;
	logic [`FPSC_LIVE_W-1:0] next_live;
	logic [`FPSC_CSR_W-1:0] next_csr_rdata;
	logic next_csr_done;
	logic [`FPSC_ROUND_W-1:0] cur_round;
	logic [`FPSC_FLAG_W-1:0] cur_flags;
	logic [`FPSC_ROUND_W-1:0] new_round;
	logic [`FPSC_FLAG_W-1:0] new_flags;
	logic [`FPSC_FLAG_W-1:0] raised;
	fpsc_pkg::fpsc_csr_op_e op;

	// Field views of the stored bits, laid out as the whole register
	assign cur_round = round_of(`FPSC_CSR_W'(live)); // [RULE5]
	assign cur_flags = flags_of(`FPSC_CSR_W'(live)); // [RULE7]

	// Access kind as the pipeline encodes it
	assign op = fpsc_pkg::fpsc_csr_op_e'(csr_op);

	// Flags raised this cycle; they never trap, only accumulate
	assign raised = flag_valid ? flag_bits : '0; // [RULE15]

	// Access decode, read value and new field values
	always_comb begin
		new_round = cur_round;
		new_flags = cur_flags;
		next_csr_rdata = '0;
		next_csr_done = 1'b0;
		if (csr_req) begin
			next_csr_done = 1'b1;
			case (op)
				fpsc_pkg::read_full_fp_control: begin
					next_csr_rdata = csr_view(cur_round, cur_flags); // [RULE3]
				end
				fpsc_pkg::swap_full_fp_control: begin
					next_csr_rdata = csr_view(cur_round, cur_flags); // [RULE4]
					new_round = round_of(src_int_reg);
					new_flags = flags_of(src_int_reg);
					// Upper source bits are dropped here [RULE8]
				end
				fpsc_pkg::read_round_field: begin
					next_csr_rdata = round_word(cur_round); // [RULE5]
				end
				fpsc_pkg::swap_round_field: begin
					next_csr_rdata = round_word(cur_round); // [RULE6]
					new_round = src_int_reg[`FPSC_ROUND_W-1:0];
				end
				fpsc_pkg::read_flag_field: begin
					next_csr_rdata = flag_word(cur_flags); // [RULE7]
				end
				fpsc_pkg::swap_flag_field: begin
					next_csr_rdata = flag_word(cur_flags); // [RULE7]
					new_flags = src_int_reg[`FPSC_FLAG_W-1:0];
				end
				default: begin
					// Unknown access kinds complete with zero, no write
					next_csr_rdata = '0;
				end
			endcase
		end
		// A flag raised in the cycle of a write survives it
		next_live = {new_round, new_flags | raised}; // [RULE14]
	end

	// Control register and access answer
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			live <= `FPSC_LIVE_RESET;
			csr_rdata <= '0;
			csr_done <= 1'b0;
		end else if (clk_en) begin
			live <= next_live; // [RULE2]
			csr_rdata <= next_csr_rdata;
			csr_done <= next_csr_done;
		end
	end

	// ------------------------------------------------------------
	// Rounding resolution
	// ------------------------------------------------------------
	logic [`FPSC_ROUND_W-1:0] next_round_mode;
	logic next_round_illegal;
	logic next_round_done;

	// Static code wins unless it asks for the dynamic field
	always_comb begin
		next_round_done = round_req;
		next_round_mode = round_mode;
		next_round_illegal = round_illegal;
		if (round_req) begin
			// Decoded the same way whether or not the result uses it
			if (instr_round_field == `FPSC_RC_USE_DYNAMIC) begin // [RULE13]
				next_round_mode = cur_round; // [RULE10]
				next_round_illegal = round_reserved(cur_round); // [RULE12]
			end else begin
				next_round_mode = instr_round_field; // [RULE11]
				next_round_illegal = round_reserved(instr_round_field);
			end
		end
	end

	// Resolved mode held until the next request
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			round_mode <= fpsc_pkg::nearest_even;
			round_illegal <= 1'b0;
			round_done <= 1'b0;
		end else if (clk_en) begin
			round_mode <= next_round_mode;
			round_illegal <= next_round_illegal;
			round_done <= next_round_done;
		end
	end

	// ------------------------------------------------------------
	// Live field view
	// ------------------------------------------------------------
	logic [`FPSC_ROUND_W-1:0] next_dynamic_round;
	logic [`FPSC_FLAG_W-1:0] next_accrued;

	// Mirrors follow the register as it will be after this edge, so a
	// swap and the view of it land at one and the same edge
	always_comb begin
		next_dynamic_round = round_of(`FPSC_CSR_W'(next_live));
		next_accrued = flags_of(`FPSC_CSR_W'(next_live)); // [RULE16]
	end

	// Mirror flops so the view comes straight from a register; the
	// reset values are those of the stored bits
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			dynamic_round <= round_of(`FPSC_CSR_W'(`FPSC_LIVE_RESET));
			accrued_flags <= flags_of(`FPSC_CSR_W'(`FPSC_LIVE_RESET));
		end else if (clk_en) begin
			dynamic_round <= next_dynamic_round;
			accrued_flags <= next_accrued;
		end
	end
endmodule : fpsc_top
`default_nettype wire

// File: tb/fpsc_top_asserts.sv
/* Checker of control access, rounding and flag ports of fpsc_top.
 Assumes it is bound to fpsc_top and sees only its ports. */
`default_nettype none
module fpsc_top_asserts (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	input wire logic clk_en,
	// Watched ports
	input wire logic csr_req,
	input wire logic [2:0] csr_op,
	input wire logic [31:0] src_int_reg,
	input wire logic csr_done,
	input wire logic [31:0] csr_rdata,
	input wire logic round_req,
	input wire logic [2:0] instr_round_field,
	input wire logic round_done,
	input wire logic [2:0] round_mode,
	input wire logic round_illegal,
	input wire logic flag_valid,
	input wire logic [4:0] flag_bits,
	input wire logic [2:0] dynamic_round,
	input wire logic [4:0] accrued_flags
);
	timeunit 1ns;
	timeprecision 1ps;
	logic go;
	logic swf;
	logic rq;
	logic [2:0] s_rnd;
	// Qualified requests; a reset edge takes nothing
	assign go = csr_req && clk_en && !sys_rst;
	assign swf = go && (csr_op == 3'h1 || csr_op == 3'h5);
	assign rq = round_req && clk_en && !sys_rst;
	assign s_rnd = src_int_reg[2:0];
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// --------------------------------
	// Control access
	// --------------------------------
	csr_done_a: assert property (go |=> csr_done)
		else $error("no done");
	full_read_a: assert property (go && csr_op == 3'h0 |=>
		csr_rdata == {24'h0, $past(dynamic_round), $past(accrued_flags)})
		else $error("bad full read");
	upper_zero_a: assert property (csr_rdata[31:8] == 24'h0)
		else $error("upper bits set");
	round_swap_a: assert property (go && csr_op == 3'h3 |=>
		dynamic_round == $past(s_rnd))
		else $error("bad round swap");
	// --------------------------------
	// Flags and rounding
	// --------------------------------
	flag_keep_a: assert property (!swf |=>
		(accrued_flags & $past(accrued_flags)) == $past(accrued_flags))
		else $error("flag lost");
	flag_set_a: assert property (flag_valid && clk_en && !sys_rst |=>
		(accrued_flags & $past(flag_bits)) == $past(flag_bits))
		else $error("flag not set");
	dynamic_mode_a: assert property (
		rq && instr_round_field == 3'h7 |=>
		round_done && round_mode == $past(dynamic_round))
		else $error("bad dynamic mode");
	stat_mode_a: assert property (rq && instr_round_field != 3'h7 |=>
		round_done && round_mode == $past(instr_round_field))
		else $error("bad static mode");
	mode_illegal_a: assert property (round_done |->
		round_illegal == (round_mode > 3'h4))
		else $error("bad illegal flag");
	// Main scenarios
	cover property (swf ##1 csr_done);
	cover property (rq && instr_round_field == 3'h7);
	cover property (flag_valid && clk_en);
endmodule : fpsc_top_asserts
bind fpsc_top fpsc_top_asserts u_chk (.clk, .sys_rst, .clk_en, .csr_req,
	.csr_op, .src_int_reg, .csr_done, .csr_rdata, .round_req,
	.instr_round_field, .round_done, .round_mode, .round_illegal,
	.flag_valid, .flag_bits, .dynamic_round, .accrued_flags);
`default_nettype wire

// File: tb/fpsc_pipe_model.sv
/* Arithmetic side of the pipeline: raises exception flags at random.
 Assumes the bench clock and reset. */
`default_nettype none
module fpsc_pipe_model (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Raised flags
	output logic flag_valid,
	output logic [4:0] flag_bits
);
	timeunit 1ns;
	timeprecision 1ps;
	integer seed = 15517;
	// Bits change every cycle, so idle values are never stale
	initial begin
		flag_valid = 1'b0;
		flag_bits = 5'h00;
	end
	always @(posedge clk) begin
		flag_valid <= !sys_rst && ($random(seed) % 3 == 0);
		flag_bits <= $random(seed);
	end
endmodule : fpsc_pipe_model
`default_nettype wire

// File: tb/fp_state_and_control_csr_bench.sv
/* Bench of fpsc_top: random traffic, corner cases, reference model.
 Assumes fpsc_top, fpsc_pipe_model and the checker are compiled. */
`default_nettype none
`define CHK(n, e, s) begin n_checks++; if ((e) !== (s)) begin errors++; \
	$display("mismatch %s exp %h got %h", n, e, s); end end
module fp_state_and_control_csr_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, sys_rst = 1, clk_en = 0, fp_wr_en = 0;
	logic csr_req = 0, round_req = 0, fv, done, rdone, ill, live = 0;
	logic e_done, e_rdone, e_ill;
	logic [4:0] wa = 0, ra = 0, rb = 0, rc = 0, fbits, acc, m_flg, nf;
	logic [31:0] wd = 0, src = 0, rda, rdb, rdc, rdata;
	logic [31:0] m_rf [32], e_rd, e_a, e_b, e_c;
	logic [2:0] op = 0, fld = 0, mode, drnd, m_rnd, e_mode;
	integer seed = 15517, errors = 0, n_checks = 0;
	// Clock
	always #2.5 clk = ~clk;
	// Expected answer of an access from the old field values
	function automatic logic [31:0] exp_rd(input logic [2:0] o,
		input logic [2:0] r, input logic [4:0] f);
		case (o)
		3'h0, 3'h1: return {24'h0, r, f};
		3'h2, 3'h3: return {29'h0, r};
		3'h4, 3'h5: return {27'h0, f};
		default: return 32'h0;
		endcase
	endfunction : exp_rd
	// Resolved rounding mode
	function automatic logic [2:0] res(input logic [2:0] c, r);
		return (c == 3'h7) ? r : c;
	endfunction : res
	fpsc_top DUT (.clk, .sys_rst, .clk_en, .fp_wr_en, .fp_wr_addr(wa),
		.fp_wr_data(wd), .fp_rd_addr_a(ra), .fp_rd_addr_b(rb),
		.fp_rd_addr_c(rc), .fp_rd_data_a(rda), .fp_rd_data_b(rdb),
		.fp_rd_data_c(rdc), .csr_req, .csr_op(op), .src_int_reg(src),
		.csr_done(done), .csr_rdata(rdata), .round_req,
		.instr_round_field(fld), .round_done(rdone), .round_mode(mode),
		.round_illegal(ill), .flag_valid(fv), .flag_bits(fbits),
		.dynamic_round(drnd), .accrued_flags(acc));
	fpsc_pipe_model u_pipe (.clk, .sys_rst, .flag_valid(fv),
		.flag_bits(fbits));
	// Compare last edge's results, then advance the reference state
	always @(posedge clk) begin
		if (live) begin
			`CHK("csr_done", e_done, done)
			`CHK("csr_rdata", e_rd, rdata)
			`CHK("round_done", e_rdone, rdone)
			`CHK("round_mode", e_mode, mode)
			`CHK("round_illegal", e_ill, ill)
			`CHK("dynamic_round", m_rnd, drnd)
			`CHK("accrued_flags", m_flg, acc)
			`CHK("rd_a", e_a, rda)
			`CHK("rd_b", e_b, rdb)
			`CHK("rd_c", e_c, rdc)
		end
		if (sys_rst) begin
			{m_rnd, m_flg, e_done, e_rd, e_rdone, e_mode, e_ill} <= '0;
			{e_a, e_b, e_c} <= '0;
			foreach (m_rf[i]) m_rf[i] <= 32'h0;
			live <= 1'b1;
		end else if (clk_en) begin
			nf = m_flg | (fv ? fbits : 5'h00);
			if (csr_req && (op == 3'h1 || op == 3'h5))
				nf = src[4:0] | (fv ? fbits : 5'h00);
			if (csr_req && op == 3'h1)
				m_rnd <= src[7:5];
			if (csr_req && op == 3'h3)
				m_rnd <= src[2:0];
			m_flg <= nf;
			e_done <= csr_req;
			e_rd <= csr_req ? exp_rd(op, m_rnd, m_flg) : 32'h0;
			e_rdone <= round_req;
			if (round_req) begin
				e_mode <= res(fld, m_rnd);
				e_ill <= res(fld, m_rnd) > 3'h4;
			end
			e_a <= m_rf[ra];
			e_b <= m_rf[rb];
			e_c <= m_rf[rc];
			if (fp_wr_en)
				m_rf[wa] <= wd;
		end
	end
	// One cycle of random traffic on every input except reset and the flags
	task automatic step();
		@(posedge clk);
		clk_en <= ($random(seed) & 7) != 0;
		csr_req <= $random(seed);
		op <= $random(seed);
		src <= $random(seed);
		round_req <= $random(seed);
		fld <= $random(seed);
		fp_wr_en <= $random(seed);
		wa <= $random(seed);
		wd <= $random(seed);
		ra <= $random(seed);
		rb <= $random(seed);
		rc <= $random(seed);
	endtask : step
	// One control access in the next cycle
	task automatic csr(input logic [2:0] o, input logic [31:0] s);
		@(posedge clk);
		clk_en <= 1'b1;
		csr_req <= 1'b1;
		op <= o;
		src <= s;
	endtask : csr
	task automatic final_report();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : final_report
	// Watchdog
	initial begin
		#50000;
		errors++;
		final_report();
	end
	// Main sequence
	initial begin
		repeat (16) @(posedge clk);
		sys_rst <= 1'b0;
		repeat (2000) step();
		$display("test random done");
		csr(3'h1, 32'hffff_ffff);
		csr(3'h0, 32'h0);
		csr(3'h5, 32'hffff_ffe0);
		csr(3'h2, 32'h0);
		csr(3'h3, 32'h0000_0105);
		csr(3'h6, 32'hffff_ffff);
		csr(3'h1, 32'h0000_0041);
		csr(3'h4, 32'h0);
		$display("test corner done");
		@(posedge clk);
		sys_rst <= 1'b1;
		repeat (3) step();
		sys_rst <= 1'b0;
		repeat (500) step();
		$display("test reset done");
		final_report();
	end
endmodule : fp_state_and_control_csr_bench
`default_nettype wire
